// File: design/drc_defs.svh
// Purpose: constants for the dram refresh and access controller
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: cycle counts are in clock periods
//
// Functional notes
// R1: access needs request plus chip select; refresh internal/external
// R2: advanced mode reads status at strobe fall
// R3: advanced mode: no external transparent refresh chaining
// R4: timer flags refresh due, restarts on refresh
// R5: refresh counter increments after each refresh
// R6: 4K: six-bit row/column, top bit chip select
// R7: 16K: seven-bit row and column multiplexed
// R8: two bank bits pick one row strobe
// R9: mode strap enables advanced read, kills banks 0-1
// R10: idle arbiter samples requests every rising edge
// R11: read plus write runs test cycle
// R12: pending refresh request remembered until served
// R13: simultaneous access and refresh: access first
// R14: write: row, early ack, row strobe, column, enable
// R15: transfer ack near end; delayed mode moves ack
// R16: end: outputs off, delayed mode cleared, precharge
// R17: refresh timer counts during accesses
// R18: refresh request during access chains refresh after
// R19: read equals write without write enable
// R20: refresh: timer restart, counter address, strobes, increment
// R21: host pulses refresh during preceding command cycle
// R22: chip select gates requests, never aborts cycles
// R23: access during refresh sets delayed ack mode
// R24: address outputs are inverted
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_RAS_CAS_CYC 4'h2
`define DRC_CAS_CYC 4'h5
`define DRC_TRANSFER_ACK_N_AT 4'h5
`define DRC_ACC_LEN 4'h9
`define DRC_REF_LEN 4'h6
`define DRC_PRE_CYC 4'h4
`define DRC_TIMER_RST 10'h100
`define DRC_REF_PERIOD_64 10'h224
`define DRC_REF_PERIOD_128 10'h108
`endif

// File: design/drc_pkg.sv
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_IDLE, DRC_ACCESS, DRC_REFRESH, DRC_PRECHARGE
  } drc_state_t;
endpackage

// File: design/drc_controller.sv
// Purpose: arbitrates access, test and refresh cycles for four dram banks
// Assumes: host inputs synchronous to mclk_in; straps static
// Notes: one access or refresh at a time; precharge after each
//   requests arriving mid-cycle wait; refresh requests are remembered
//   straps are read every cycle and must not change while a cycle runs
`include "drc_defs.svh"
module drc_controller import drc_pkg::*; #(
  parameter int REF_PERIOD_64 = 548,
  parameter int REF_PERIOD_128 = 264
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic read_request_or_status_in,
  input wire logic write_request_n_in,
  input wire logic protected_select_n_in,
  input wire logic refresh_request_or_latch_in,
  input wire logic [5:0] row_address_in,
  input wire logic row_msb_or_size_strap_in,
  input wire logic size_4k_strap_in,
  input wire logic [6:0] column_address_in,
  input wire logic bank_select_low_in,
  input wire logic bank_select_high_or_mode_strap_in,
  input wire logic advanced_read_strap_in,
  output logic [6:0] mux_address_out_n_out,
  output logic [3:0] bank_row_strobe_n_out,
  output logic column_strobe_n_out,
  output logic write_enable_n_out,
  output logic transfer_ack_n_out,
  output logic system_ack_n_out
);

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic prev_latch;
  logic next_prev_latch;
  logic latched_status;
  logic next_latched_status;
  logic rd_req;
  logic wr_req;
  logic ext_ref;
  logic access_taken;

  // the latched status is a one-shot read request: it drops once the
  // sequencer takes it, otherwise one status pulse would repeat forever
  always_comb begin
    next_prev_latch = refresh_request_or_latch_in;
    next_latched_status = latched_status;
    if (access_taken) begin
      next_latched_status = 1'b0;
    end
    if (advanced_read_strap_in && prev_latch && !refresh_request_or_latch_in) begin
      next_latched_status = read_request_or_status_in; // R2
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prev_latch <= 1'b0;
      latched_status <= 1'b0;
    end else begin
      prev_latch <= next_prev_latch;
      latched_status <= next_latched_status;
    end
  end

  always_comb begin
    if (advanced_read_strap_in) begin
      rd_req = latched_status && !protected_select_n_in; // R2 R22
      ext_ref = 1'b0; // R3
    end else begin
      // plain levels here, nothing is latched, so an access request has to stand
      // until the sequencer is idle and takes it
      rd_req = !read_request_or_status_in && !protected_select_n_in; // R1 R22
      ext_ref = refresh_request_or_latch_in; // R1
    end
    wr_req = !write_request_n_in && !protected_select_n_in; // R1 R22
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  drc_state_t state;
  drc_state_t next_state;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic is_write;
  logic next_is_write;
  logic [1:0] bank;
  logic [1:0] next_bank;
  logic [6:0] row_l;
  logic [6:0] next_row_l;
  logic [6:0] col_l;
  logic [6:0] next_col_l;
  logic ref_pend;
  logic next_ref_pend;
  logic delayed_mode;
  logic next_delayed_mode;
  logic [6:0] ref_row;
  logic [6:0] next_ref_row;
  logic [9:0] ref_timer;
  logic [9:0] next_ref_timer;
  logic timer_due;
  logic [9:0] timer_init;
  logic [6:0] next_addr_n;
  logic [3:0] next_ras_n;
  logic next_cas_n;
  logic next_we_n;
  logic next_transfer_ack_n_n;
  logic next_system_ack_n_n;
  logic ref_start;
  logic ref_done;
  logic ref_clear;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // one-hot strobe selection; advanced mode blocks banks 0 and 1
  function automatic logic [3:0] bank_strobe(input logic [1:0] b, input logic adv);
    logic [3:0] s;
    s = 4'hf;
    s[b] = 1'b0; // R8
    if (adv) begin
      s[1:0] = 2'h3; // R9
    end
    return s;
  endfunction

  // the address pins are active low, so every source is complemented here
  function automatic logic [6:0] addr_drive(input logic [6:0] a);
    return ~a; // R24
  endfunction

  // refresh strobes every enabled bank at once; advanced mode keeps 0 and 1 idle
  function automatic logic [3:0] refresh_strobes(input logic adv);
    logic [3:0] s;
    s = 4'h0;
    if (adv) begin
      s[1:0] = 2'h3; // R9
    end
    return s;
  endfunction

  // small parts put the top column bit on the top address pin for the
  // whole access, where it serves as the array's chip select
  function automatic logic [6:0] capture_row(input logic is_small, input logic msb,
      input logic [5:0] low, input logic sel);
    logic [6:0] r;
    r = {msb, low}; // R7
    if (is_small) begin
      r = {sel, low}; // R6
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // refresh bookkeeping
  // ----------------------------------------------------------------
  // a 64-row part refreshes at a little over twice the interval of a 128-row part (548 against 264 cycles)
  assign timer_init = size_4k_strap_in ? 10'(REF_PERIOD_64) : 10'(REF_PERIOD_128);
  assign timer_due = (ref_timer == 10'h000);

  // the sequencer only raises start, done and clear events; keeping the
  // timer, pending flag and row counter here makes their priority plain
  always_comb begin
    next_ref_timer = timer_due ? ref_timer : ref_timer - 10'h001; // R17
    next_ref_pend = ref_pend || ext_ref || timer_due; // R12 R18
    next_ref_row = ref_row;
    if (ref_start) begin
      next_ref_timer = timer_init; // R4 R20
      next_ref_pend = 1'b0;
    end
    if (ref_done) begin
      next_ref_row = ref_row + 7'h01; // R5 R20
    end
    if (ref_clear) begin
      next_ref_row = 7'h00; // R11
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ref_pend <= 1'b0;
      ref_row <= 7'h00;
      ref_timer <= `DRC_TIMER_RST;
    end else begin
      ref_pend <= next_ref_pend;
      ref_row <= next_ref_row;
      ref_timer <= next_ref_timer;
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_is_write = is_write;
    next_bank = bank;
    next_row_l = row_l;
    next_col_l = col_l;
    next_delayed_mode = delayed_mode;
    access_taken = 1'b0;
    ref_start = 1'b0;
    ref_done = 1'b0;
    ref_clear = 1'b0;
    next_addr_n = mux_address_out_n_out;
    next_ras_n = 4'hf;
    next_cas_n = 1'b1;
    next_we_n = 1'b1;
    next_transfer_ack_n_n = 1'b1;
    next_system_ack_n_n = 1'b1;
    case (state)
      DRC_IDLE: begin
        if (rd_req || wr_req) begin // R10 R13
          access_taken = 1'b1;
          next_state = DRC_ACCESS;
          next_phase = 4'h0;
          next_is_write = wr_req;
          next_bank = {bank_select_high_or_mode_strap_in, bank_select_low_in};
          next_row_l = capture_row(size_4k_strap_in, row_msb_or_size_strap_in,
              row_address_in, column_address_in[6]); // R6 R7
          next_col_l = column_address_in; // R6 R7
          // a test cycle is an ordinary write that also clears the refresh row counter and delayed mode
          if (rd_req && wr_req) begin
            ref_clear = 1'b1; // R11
            next_delayed_mode = 1'b0; // R11
            next_is_write = 1'b1; // R11
          end
          next_addr_n = addr_drive(next_row_l); // R14 R24
          if (!(next_delayed_mode)) begin
            next_system_ack_n_n = 1'b0; // R14
          end
        end else if (ref_pend || ext_ref || timer_due) begin // R10 R12
          next_state = DRC_REFRESH;
          next_phase = 4'h0;
          ref_start = 1'b1; // R4 R20
          next_addr_n = addr_drive(ref_row); // R20 R24
          next_ras_n = refresh_strobes(advanced_read_strap_in); // R20 R9
        end
      end
      DRC_ACCESS: begin
        // the column address goes out one phase ahead of the column strobe
        // so the array sees it settled when the strobe falls
        next_phase = phase + 4'h1;
        next_system_ack_n_n = system_ack_n_out;
        next_ras_n = bank_strobe(bank, advanced_read_strap_in); // R8 R14
        if (phase >= `DRC_RAS_CAS_CYC - 4'h1) begin
          next_addr_n = addr_drive(col_l); // R14 R24
          next_we_n = !is_write; // R14 R19
        end
        if (phase >= `DRC_RAS_CAS_CYC) begin
          next_cas_n = 1'b0; // R14
        end
        if (phase >= `DRC_TRANSFER_ACK_N_AT + `DRC_RAS_CAS_CYC) begin
          next_transfer_ack_n_n = 1'b0; // R15
          next_system_ack_n_n = 1'b0; // R15
        end
        if (phase == `DRC_ACC_LEN) begin
          next_ras_n = 4'hf; // R16
          next_cas_n = 1'b1;
          next_we_n = 1'b1;
          next_transfer_ack_n_n = 1'b1;
          next_system_ack_n_n = 1'b1;
          next_delayed_mode = 1'b0; // R16
          next_state = DRC_PRECHARGE;
          next_phase = 4'h0;
        end
      end
      DRC_REFRESH: begin
        // an access asked for here waits out the refresh, so its early
        // system ack would be a lie; it is held back to the transfer ack
        next_phase = phase + 4'h1;
        next_ras_n = refresh_strobes(advanced_read_strap_in); // R20
        if (rd_req || wr_req) begin
          next_delayed_mode = 1'b1; // R23
        end
        if (phase == `DRC_REF_LEN) begin
          next_ras_n = 4'hf; // R20
          ref_done = 1'b1; // R5 R20
          next_state = DRC_PRECHARGE;
          next_phase = 4'h0;
        end
      end
      DRC_PRECHARGE: begin
        next_phase = phase + 4'h1;
        if (rd_req || wr_req) begin
          next_delayed_mode = delayed_mode;
        end
        if (phase == `DRC_PRE_CYC - 4'h1) begin
          next_state = DRC_IDLE; // R16
        end
      end
      default: begin
        next_state = DRC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= DRC_IDLE;
      phase <= 4'h0;
      is_write <= 1'b0;
      bank <= 2'h0;
      row_l <= 7'h00;
      col_l <= 7'h00;
      delayed_mode <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      is_write <= next_is_write;
      bank <= next_bank;
      row_l <= next_row_l;
      col_l <= next_col_l;
      delayed_mode <= next_delayed_mode;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // every pin comes straight from a flop so neither side sees decode
  // glitches; the cost is one clock of latency on each strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mux_address_out_n_out <= 7'h7f;
      bank_row_strobe_n_out <= 4'hf;
      column_strobe_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      transfer_ack_n_out <= 1'b1;
      system_ack_n_out <= 1'b1;
    end else begin
      mux_address_out_n_out <= next_addr_n;
      bank_row_strobe_n_out <= next_ras_n;
      column_strobe_n_out <= next_cas_n;
      write_enable_n_out <= next_we_n;
      transfer_ack_n_out <= next_transfer_ack_n_n;
      system_ack_n_out <= next_system_ack_n_n;
    end
  end

endmodule

// File: sim/drc_controller_properties.sv
// Purpose: port-level timing checks for drc_controller
// Assumes: normal read mode; bank inputs held while an access runs
// Notes: cycle figures follow the hand-over walk
module drc_checker(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [5:0] row_address_in,
  input wire logic bank_select_low_in,
  input wire logic bank_select_high_or_mode_strap_in,
  input wire logic [6:0] mux_address_out_n_out,
  input wire logic [3:0] bank_row_strobe_n_out,
  input wire logic column_strobe_n_out,
  input wire logic write_enable_n_out,
  input wire logic transfer_ack_n_out,
  input wire logic system_ack_n_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  a_cas_ras_gap: assert property ($fell(column_strobe_n_out) |->
    $past(bank_row_strobe_n_out, 2) != 4'hf && $past(bank_row_strobe_n_out, 3) == 4'hf)
    else $error("cas not two cycles after ras");
  a_transfer_ack_n_delay: assert property ($fell(column_strobe_n_out) |-> ##5 $fell(transfer_ack_n_out))
    else $error("transfer_ack_n not five cycles after cas");
  a_we_to_cas: assert property ($fell(write_enable_n_out) |=> $fell(column_strobe_n_out))
    else $error("we not one cycle before cas");
  a_bank_strobe: assert property ($fell(column_strobe_n_out) |->
    bank_row_strobe_n_out == ~(4'h1 << {bank_select_high_or_mode_strap_in, bank_select_low_in}))
    else $error("wrong bank strobe");
  a_row_addr: assert property ($fell(system_ack_n_out) && transfer_ack_n_out |->
    mux_address_out_n_out[5:0] == ~row_address_in)
    else $error("row address wrong");
  a_system_ack_n_early: assert property ($fell(system_ack_n_out) && transfer_ack_n_out |=>
    bank_row_strobe_n_out != 4'hf)
    else $error("ras not after early system_ack_n");
  a_ack_end: assert property ($fell(transfer_ack_n_out) |-> ##3 &{transfer_ack_n_out,
    system_ack_n_out, column_strobe_n_out, write_enable_n_out, bank_row_strobe_n_out})
    else $error("outputs not released");
  a_precharge: assert property ($rose(&bank_row_strobe_n_out) |->
    (&bank_row_strobe_n_out) [*4])
    else $error("precharge too short");
  cover property ($fell(write_enable_n_out));
  cover property (bank_row_strobe_n_out == 4'h0);
  cover property ($fell(system_ack_n_out) && $fell(transfer_ack_n_out));
endmodule
bind drc_controller drc_checker i_chk (.*);

// File: sim/drc_dram_model.sv
// Purpose: far-side dram array, latches strobed addresses
// Assumes: strobes active low, address bus inverted
// Notes: a refresh shows as a row latch without a column
module drc_dram_model(
  input wire logic clk_in,
  input wire logic [6:0] addr_n_in,
  input wire logic [3:0] ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  output logic [6:0] row_out,
  output logic [6:0] col_out,
  output logic wr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;
  always @(posedge clk_in) begin
    ras_q <= &ras_n_in;
    cas_q <= cas_n_in;
    if (ras_q && !(&ras_n_in)) row_out <= ~addr_n_in;
    if (cas_q && !cas_n_in) begin
      col_out <= ~addr_n_in;
      wr_out <= ~we_n_in;
    end
  end
endmodule

// File: sim/tb_dram_refresh_access_controller.sv
// Purpose: self-checking bench for drc_controller
// Assumes: normal read mode, 16k addressing
// Notes: driver queues expectations, monitor pops them on transfer_ack_n
module tb_dram_refresh_access_controller;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rd_n = 1'b1, wr_n = 1'b1, pcs_n = 1'b1, rfq = 1'b0, msb = 1'b0, bl = 1'b0, bh = 1'b0;
  logic [5:0] row = 6'h00;
  logic [6:0] col = 7'h00, addr_n, p_row, p_col;
  logic [3:0] ras_n;
  logic cas_n, we_n, transfer_ack_n_n, system_ack_n_n, p_wr, xq, sq;
  logic [15:0] s = 16'h45c9;
  logic [15:0] exq[$];
  int fails = 0;
  int checks_done = 0;
  always #5 mclk_in = ~mclk_in;
  drc_controller i_dut(.mclk_in(mclk_in), .rst_in(rst_in), .read_request_or_status_in(rd_n),
    .write_request_n_in(wr_n), .protected_select_n_in(pcs_n), .refresh_request_or_latch_in(rfq),
    .row_address_in(row), .row_msb_or_size_strap_in(msb), .size_4k_strap_in(1'b0),
    .column_address_in(col), .bank_select_low_in(bl), .bank_select_high_or_mode_strap_in(bh),
    .advanced_read_strap_in(1'b0), .mux_address_out_n_out(addr_n),
    .bank_row_strobe_n_out(ras_n), .column_strobe_n_out(cas_n), .write_enable_n_out(we_n),
    .transfer_ack_n_out(transfer_ack_n_n), .system_ack_n_out(system_ack_n_n));
  drc_dram_model i_ram(.clk_in(mclk_in), .addr_n_in(addr_n), .ras_n_in(ras_n),
    .cas_n_in(cas_n), .we_n_in(we_n), .row_out(p_row), .col_out(p_col), .wr_out(p_wr));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // ----------------------------------------
  // checks and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // expectation is {delayed system_ack_n, write, row, column}
  task automatic acc(input logic r, input logic w, input logic d);
    s = lfsr(s);
    @(posedge mclk_in);
    {bh, bl, col, msb, row} <= s;
    rd_n <= ~r;
    wr_n <= ~w;
    pcs_n <= 1'b0;
    exq.push_back({d, w, s[6:0], s[13:7]});
    repeat (40) begin
      @(posedge mclk_in);
      if (transfer_ack_n_n === 1'b0) break;
    end
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    pcs_n <= 1'b1;
  endtask
  task automatic rfsh();
    @(posedge mclk_in);
    rfq <= 1'b1;
    @(posedge mclk_in);
    rfq <= 1'b0;
  endtask
  task automatic ref_row(input logic [6:0] e);
    repeat (700) begin
      @(posedge mclk_in);
      if (ras_n === 4'h0) break;
    end
    @(posedge mclk_in);
    chk("refresh row", {9'h000, p_row}, {9'h000, e});
    // let the refresh and its precharge finish before the next request
    repeat (12) @(posedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    xq <= transfer_ack_n_n;
    sq <= system_ack_n_n;
    if (xq === 1'b1 && transfer_ack_n_n === 1'b0) begin
      if (exq.size() == 0) chk("spurious ack", 16'h0001, 16'h0000);
      else chk("access", {sq, p_wr, p_row, p_col}, exq.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    acc(1'b1, 1'b1, 1'b0);
    rfsh();
    ref_row(7'h00);
    // refresh pulsed in the same cycle as the access it should follow
    fork
      acc(1'b0, 1'b1, 1'b0);
      rfsh();
    join
    ref_row(7'h01);
    rfsh();
    acc(1'b1, 1'b0, 1'b1);
    repeat (6) acc(s[1], ~s[1], 1'b0);
    @(posedge mclk_in);
    rd_n <= 1'b0;
    repeat (20) @(posedge mclk_in);
    rd_n <= 1'b1;
    ref_row(7'h03);
    acc(1'b1, 1'b1, 1'b0);
    rfsh();
    ref_row(7'h00);
    chk("queue left", 16'(exq.size()), 16'h0000);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge mclk_in);
    fails++;
    final_report();
  end
endmodule
